// ---- spc_pkg.sv ----
// Shared constants of the serial port control and capability register bank.
// Assumes a 32-bit maintenance slave port with byte addresses and four byte enables.
`default_nettype none

package spc_pkg;

    // Maintenance port geometry.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_PART_IDENTITY = 16'h0000;
    localparam logic [ADDR_W-1:0] OFS_PART_REVISION_INFO = 16'h0004;
    localparam logic [ADDR_W-1:0] OFS_BOARD_ASSEMBLY_IDENTITY = 16'h0008;
    localparam logic [ADDR_W-1:0] OFS_BOARD_ASSEMBLY_INFO = 16'h000c;
    localparam logic [ADDR_W-1:0] OFS_LINK_PORT_CONTROL = 16'h015c;

    // Field positions inside the link port control register.
    localparam int POS_RECEIVE_ACCEPT_ENABLE = 21;
    localparam int POS_ERROR_RECOVERY_OFF = 20;
    localparam int POS_MCAST_PARTICIPANT = 19;
    localparam int POS_ENUM_BOUNDARY = 17;
    localparam int POS_RETX_MASK_LO = 4;
    localparam int POS_RETX_MASK_HI = 11;
    localparam int POS_PORT_TYPE = 0;

    // Byte lane that carries the writable control fields.
    localparam int CTRL_WRITE_LANE = 2;

    // Reset values of the writable control fields and constant fields.
    localparam logic RST_RECEIVE_ACCEPT_ENABLE = 1'b1;
    localparam logic RST_ERROR_RECOVERY_OFF = 1'b0;
    localparam logic RST_MCAST_PARTICIPANT = 1'b0;
    localparam logic VAL_ENUM_BOUNDARY = 1'b0;
    localparam logic [7:0] VAL_RETX_MASK = 8'h00;
    localparam logic VAL_PORT_TYPE_SERIAL = 1'b1;

    // Legal range of the first extended feature pointer.
    localparam logic [15:0] FEATURE_PTR_MIN = 16'h0100;
    localparam logic [15:0] FEATURE_PTR_MAX = 16'hfffc;

    // Answer to an unmapped read.
    localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 32'h00000000;

endpackage

`default_nettype wire

// ---- spc_regs.sv ----
// Port control and capability register bank of a serial endpoint, with receive gating.
// Assumes a maintenance master on the same clock that holds each request for one cycle,
// and packet logic on the same clock that presents one classified request at a time.
//
// Function
// - Receive disabled: only maintenance accepted, others refused.
// - Receive enabled accepts all; read-write, resets one.
// - Error-check-off bit read-write, resets zero, disables recovery.
// - Multicast bit resets zero, forwards multicast symbols.
// - Enumeration boundary and retransmit mask read zero.
// - Port type bit always reads one.
// - Registers reachable over maintenance slave port.
// - Offset zero: fixed part and maker identifiers.
// - Offset four: fixed 32-bit part revision.
// - Offset eight: fixed assembly and assembly maker identifiers.
// - Offset twelve upper half: fixed assembly revision.
// - Offset twelve lower half: feature pointer in range.
`default_nettype none

module spc_regs
    import spc_pkg::*;
#(
    // Build-time identity values; the defaults are arbitrary.
    parameter logic [15:0] PART_IDENTIFIER = 16'h1234,
    parameter logic [15:0] MAKER_IDENTIFIER = 16'h5678,
    parameter logic [31:0] PART_REVISION = 32'h00000001,
    parameter logic [15:0] BOARD_ASSEMBLY_IDENTIFIER = 16'h0abc,
    parameter logic [15:0] BOARD_MAKER_IDENTIFIER = 16'h0def,
    parameter logic [15:0] BOARD_ASSEMBLY_REVISION = 16'h0001,
    parameter logic [15:0] FEATURE_LIST_POINTER = 16'h0100
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Maintenance slave port.
    input wire logic [ADDR_W-1:0] mnt_address,
    input wire logic mnt_read,
    input wire logic mnt_write,
    input wire logic [DATA_W-1:0] mnt_writedata,
    input wire logic [BE_W-1:0] mnt_byteenable,
    output logic [DATA_W-1:0] mnt_readdata,
    output logic mnt_readdatavalid,
    // Incoming request classification.
    input wire logic rx_pkt_valid,
    input wire logic rx_pkt_is_maint,
    output logic rx_pkt_accept,
    output logic rx_pkt_refuse,
    // Multicast event symbols.
    input wire logic mcast_sym_in,
    output logic mcast_sym_fwd,
    // Control levels towards the physical layer.
    output logic receive_accept_enable,
    output logic error_recovery_off,
    output logic mcast_participant
);

    logic receive_accept_enable_q;
    logic receive_accept_enable_d;
    logic error_recovery_off_q;
    logic error_recovery_off_d;
    logic mcast_participant_q;
    logic mcast_participant_d;
    logic [DATA_W-1:0] readdata_q;
    logic [DATA_W-1:0] readdata_d;
    logic readdatavalid_q;
    logic readdatavalid_d;
    logic mcast_fwd_q;
    logic mcast_fwd_d;
    logic ctrl_write;
    logic [DATA_W-1:0] ctrl_word;

    // Only the lane holding the writable fields matters; the other lanes carry
    // read-only or reserved bits, so writing them has no effect.
    assign ctrl_write = mnt_write && (mnt_address == OFS_LINK_PORT_CONTROL)
        && mnt_byteenable[CTRL_WRITE_LANE];

    // Readback image of the port control register; unlisted bits stay zero.
    always_comb begin
        ctrl_word = '0;
        ctrl_word[POS_RECEIVE_ACCEPT_ENABLE] = receive_accept_enable_q;
        ctrl_word[POS_ERROR_RECOVERY_OFF] = error_recovery_off_q;
        ctrl_word[POS_MCAST_PARTICIPANT] = mcast_participant_q;
        ctrl_word[POS_ENUM_BOUNDARY] = VAL_ENUM_BOUNDARY;
        ctrl_word[POS_RETX_MASK_HI:POS_RETX_MASK_LO] = VAL_RETX_MASK;
        ctrl_word[POS_PORT_TYPE] = VAL_PORT_TYPE_SERIAL;
    end

    // Next values of the writable control fields.
    always_comb begin
        receive_accept_enable_d = receive_accept_enable_q;
        error_recovery_off_d = error_recovery_off_q;
        mcast_participant_d = mcast_participant_q;
        if (ctrl_write) begin
            receive_accept_enable_d = mnt_writedata[POS_RECEIVE_ACCEPT_ENABLE];
            error_recovery_off_d = mnt_writedata[POS_ERROR_RECOVERY_OFF];
            mcast_participant_d = mnt_writedata[POS_MCAST_PARTICIPANT];
        end
    end

    // Control fields come out of reset with receive on and checking active.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            receive_accept_enable_q <= RST_RECEIVE_ACCEPT_ENABLE;
            error_recovery_off_q <= RST_ERROR_RECOVERY_OFF;
            mcast_participant_q <= RST_MCAST_PARTICIPANT;
        end else begin
            receive_accept_enable_q <= receive_accept_enable_d;
            error_recovery_off_q <= error_recovery_off_d;
            mcast_participant_q <= mcast_participant_d;
        end
    end

    // Read decode; an unmapped address answers zero rather than stalling the master.
    always_comb begin
        readdatavalid_d = mnt_read;
        readdata_d = readdata_q;
        if (mnt_read) begin
            unique case (mnt_address)
                OFS_PART_IDENTITY:
                    readdata_d = {PART_IDENTIFIER, MAKER_IDENTIFIER};
                OFS_PART_REVISION_INFO:
                    readdata_d = PART_REVISION;
                OFS_BOARD_ASSEMBLY_IDENTITY:
                    readdata_d = {BOARD_ASSEMBLY_IDENTIFIER, BOARD_MAKER_IDENTIFIER};
                OFS_BOARD_ASSEMBLY_INFO:
                    readdata_d = {BOARD_ASSEMBLY_REVISION, FEATURE_LIST_POINTER};
                OFS_LINK_PORT_CONTROL:
                    readdata_d = ctrl_word;
                default:
                    readdata_d = UNMAPPED_READ_VALUE;
            endcase
        end
    end

    // Read answers one cycle after the request; data holds until the next read.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata_q <= '0;
            readdatavalid_q <= 1'b0;
        end else begin
            readdata_q <= readdata_d;
            readdatavalid_q <= readdatavalid_d;
        end
    end

    // Multicast symbols pass through a register only while this port participates.
    always_comb begin
        mcast_fwd_d = mcast_sym_in && mcast_participant_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mcast_fwd_q <= 1'b0;
        end else begin
            mcast_fwd_q <= mcast_fwd_d;
        end
    end

    // Request gating is combinational so the refusal symbol goes out without delay.
    always_comb begin
        rx_pkt_accept = rx_pkt_valid && (receive_accept_enable_q || rx_pkt_is_maint);
        rx_pkt_refuse = rx_pkt_valid && !receive_accept_enable_q && !rx_pkt_is_maint;
    end

    // Output drive.
    assign mnt_readdata = readdata_q;
    assign mnt_readdatavalid = readdatavalid_q;
    assign mcast_sym_fwd = mcast_fwd_q;
    assign receive_accept_enable = receive_accept_enable_q;
    assign error_recovery_off = error_recovery_off_q;
    assign mcast_participant = mcast_participant_q;

    // Checks on the bank's behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence rd_ctrl_s;
        mnt_read && (mnt_address == OFS_LINK_PORT_CONTROL);
    endsequence

    sequence wr_ctrl_lane_s;
        mnt_write && (mnt_address == OFS_LINK_PORT_CONTROL)
            && mnt_byteenable[CTRL_WRITE_LANE];
    endsequence

    sequence wr_ctrl_nolane_s;
        mnt_write && (mnt_address == OFS_LINK_PORT_CONTROL)
            && !mnt_byteenable[CTRL_WRITE_LANE];
    endsequence

    refuse_non_maint_a: assert property (
        rx_pkt_valid && !receive_accept_enable && !rx_pkt_is_maint
            |-> rx_pkt_refuse && !rx_pkt_accept)
        else $error("Non-maintenance request not refused while receive is off.");

    maint_always_a: assert property (
        rx_pkt_valid && rx_pkt_is_maint |-> rx_pkt_accept && !rx_pkt_refuse)
        else $error("Maintenance request not accepted.");

    accept_all_a: assert property (
        rx_pkt_valid && receive_accept_enable |-> rx_pkt_accept && !rx_pkt_refuse)
        else $error("Request refused while receive is enabled.");

    enable_write_a: assert property (
        wr_ctrl_lane_s ##1 1'b1
            |-> receive_accept_enable == $past(mnt_writedata[POS_RECEIVE_ACCEPT_ENABLE]))
        else $error("Receive enable did not take the written value.");

    errchk_write_a: assert property (
        wr_ctrl_lane_s |=> error_recovery_off == $past(mnt_writedata[POS_ERROR_RECOVERY_OFF]))
        else $error("Error check disable did not take the written value.");

    mcast_fwd_a: assert property (
        mcast_sym_in |=> mcast_sym_fwd == $past(mcast_participant))
        else $error("Multicast symbol forwarding wrong.");

    no_spurious_fwd_a: assert property (
        !mcast_sym_in |=> !mcast_sym_fwd)
        else $error("Multicast symbol forwarded without input.");

    unsup_zero_a: assert property (
        rd_ctrl_s |=> mnt_readdatavalid && !mnt_readdata[POS_ENUM_BOUNDARY]
            && (mnt_readdata[POS_RETX_MASK_HI:POS_RETX_MASK_LO] == VAL_RETX_MASK))
        else $error("Unsupported control fields read nonzero.");

    port_type_a: assert property (
        rd_ctrl_s |=> mnt_readdata[POS_PORT_TYPE] == VAL_PORT_TYPE_SERIAL)
        else $error("Port type does not read serial.");

    read_answer_a: assert property (
        mnt_read |=> mnt_readdatavalid)
        else $error("Read not answered in one cycle.");

    no_extra_valid_a: assert property (
        !mnt_read |=> !mnt_readdatavalid)
        else $error("Read valid without a read.");

    ident_read_a: assert property (
        mnt_read && (mnt_address == OFS_PART_IDENTITY)
            |=> mnt_readdata == {PART_IDENTIFIER, MAKER_IDENTIFIER})
        else $error("Identity register read wrong.");

    revision_read_a: assert property (
        mnt_read && (mnt_address == OFS_PART_REVISION_INFO) |=> mnt_readdata == PART_REVISION)
        else $error("Revision register read wrong.");

    assembly_read_a: assert property (
        mnt_read && (mnt_address == OFS_BOARD_ASSEMBLY_IDENTITY)
            |=> mnt_readdata == {BOARD_ASSEMBLY_IDENTIFIER, BOARD_MAKER_IDENTIFIER})
        else $error("Assembly identity register read wrong.");

    assembly_info_a: assert property (
        mnt_read && (mnt_address == OFS_BOARD_ASSEMBLY_INFO)
            |=> mnt_readdata == {BOARD_ASSEMBLY_REVISION, FEATURE_LIST_POINTER})
        else $error("Assembly information register read wrong.");

    ptr_range_a: assert property (
        (FEATURE_LIST_POINTER >= FEATURE_PTR_MIN) && (FEATURE_LIST_POINTER <= FEATURE_PTR_MAX))
        else $error("Feature list pointer out of range.");

    ro_lane_hold_a: assert property (
        wr_ctrl_nolane_s |=> $stable(receive_accept_enable)
            && $stable(error_recovery_off) && $stable(mcast_participant))
        else $error("Control fields changed on a write without their lane.");

    reserved_zero_a: assert property (
        rd_ctrl_s |=> (mnt_readdata[31:22] == 10'h000) && !mnt_readdata[18]
            && (mnt_readdata[16:12] == 5'h00) && (mnt_readdata[3:1] == 3'h0))
        else $error("Reserved control bits read nonzero.");

endmodule

`default_nettype wire

// ---- spc_host_model.sv ----
// Host-side maintenance master model that reaches the register bank one word at a time.
// Assumes the bank answers a read on the taking edge itself, valid for the cycle that follows, with no wait.
`default_nettype none

module spc_host_model
    import spc_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Maintenance master side.
    output logic [ADDR_W-1:0] mnt_address,
    output logic mnt_read,
    output logic mnt_write,
    output logic [DATA_W-1:0] mnt_writedata,
    output logic [BE_W-1:0] mnt_byteenable,
    input wire logic [DATA_W-1:0] mnt_readdata,
    input wire logic mnt_readdatavalid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle values at time zero.
    initial begin
        mnt_address = '0;
        mnt_read = 1'b0;
        mnt_write = 1'b0;
        mnt_writedata = '0;
        mnt_byteenable = '0;
    end

    // One write pulse; released lines show the inverse so stale values never look valid.
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                             input logic [BE_W-1:0] be);
        @(negedge clk);
        mnt_address = a;
        mnt_writedata = d;
        mnt_byteenable = be;
        mnt_write = 1'b1;
        @(posedge clk);
        @(negedge clk);
        mnt_write = 1'b0;
        mnt_address = ~a;
        mnt_writedata = ~d;
        mnt_byteenable = ~be;
    endtask

    // One read pulse; the answer is taken once the valid pulse has settled.
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                            output logic ok);
        @(negedge clk);
        mnt_address = a;
        mnt_read = 1'b1;
        @(posedge clk);
        @(negedge clk);
        mnt_read = 1'b0;
        mnt_address = ~a;
        d = mnt_readdata;
        ok = mnt_readdatavalid;
    endtask
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench of the port control and capability register bank.
// Assumes the host model drives the maintenance port; gate and multicast inputs come from here.
`default_nettype none
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin \
    mismatches++; $display("BAD %0t %s", $time, msg); end end

module tb_top
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Build-time identity values handed to the bank; the values are arbitrary.
    localparam logic [15:0] T_PART = 16'h3c11;
    localparam logic [15:0] T_MAKER = 16'h4d22;
    localparam logic [31:0] T_REV = 32'h5e336f44;
    localparam logic [15:0] T_ASSY = 16'h7a55;
    localparam logic [15:0] T_AMAKER = 16'h8b66;
    localparam logic [15:0] T_AREV = 16'h9c77;
    localparam logic [15:0] T_PTR = 16'hfffc;

    logic clk, arst_n, mnt_read, mnt_write, mnt_readdatavalid;
    logic [ADDR_W-1:0] mnt_address;
    logic [DATA_W-1:0] mnt_writedata, mnt_readdata;
    logic [BE_W-1:0] mnt_byteenable;
    logic rx_pkt_valid, rx_pkt_is_maint, rx_pkt_accept, rx_pkt_refuse, mcast_sym_in;
    logic mcast_sym_fwd, receive_accept_enable, error_recovery_off, mcast_participant;
    int mismatches = 0;
    int checks_done = 0;

    spc_regs #(.PART_IDENTIFIER(T_PART), .MAKER_IDENTIFIER(T_MAKER), .PART_REVISION(T_REV),
        .BOARD_ASSEMBLY_IDENTIFIER(T_ASSY), .BOARD_MAKER_IDENTIFIER(T_AMAKER),
        .BOARD_ASSEMBLY_REVISION(T_AREV), .FEATURE_LIST_POINTER(T_PTR)) spc_regs_i (
        .clk(clk), .arst_n(arst_n), .mnt_address(mnt_address), .mnt_read(mnt_read),
        .mnt_write(mnt_write), .mnt_writedata(mnt_writedata), .mnt_byteenable(mnt_byteenable),
        .mnt_readdata(mnt_readdata), .mnt_readdatavalid(mnt_readdatavalid),
        .rx_pkt_valid(rx_pkt_valid), .rx_pkt_is_maint(rx_pkt_is_maint),
        .rx_pkt_accept(rx_pkt_accept), .rx_pkt_refuse(rx_pkt_refuse),
        .mcast_sym_in(mcast_sym_in), .mcast_sym_fwd(mcast_sym_fwd),
        .receive_accept_enable(receive_accept_enable), .error_recovery_off(error_recovery_off),
        .mcast_participant(mcast_participant));

    spc_host_model spc_host_model_i (.clk(clk), .mnt_address(mnt_address),
        .mnt_read(mnt_read), .mnt_write(mnt_write), .mnt_writedata(mnt_writedata),
        .mnt_byteenable(mnt_byteenable), .mnt_readdata(mnt_readdata),
        .mnt_readdatavalid(mnt_readdatavalid));

    // A 4 ns clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Reads one word and expects a valid answer carrying the given value.
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        logic ok;
        spc_host_model_i.read_reg(a, d, ok);
        `CHK(ok, 1'b1, "read answer missing")
        `CHK(d, exp, "read data")
    endtask

    // Walks every valid and class combination of the packet gate for a given enable.
    task automatic gate_sweep(input logic en);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            rx_pkt_valid = i[0];
            rx_pkt_is_maint = i[1];
            #1;
            `CHK(rx_pkt_accept, i[0] & (en | i[1]), "accept")
            `CHK(rx_pkt_refuse, i[0] & ~en & ~i[1], "refuse")
        end
    endtask

    // One multicast pulse; the forward pulse, when expected, must appear for exactly one cycle.
    task automatic mc_pulse(input logic exp);
        @(negedge clk);
        mcast_sym_in = 1'b1;
        @(negedge clk);
        mcast_sym_in = 1'b0;
        `CHK(mcast_sym_fwd, exp, "forward pulse")
        @(negedge clk);
        `CHK(mcast_sym_fwd, 1'b0, "forward width")
    endtask

    // Main sequence.
    initial begin
        arst_n = 1'b0;
        rx_pkt_valid = 1'b0;
        rx_pkt_is_maint = 1'b0;
        mcast_sym_in = 1'b0;
        repeat (4) @(posedge clk);
        `CHK({receive_accept_enable, error_recovery_off, mcast_participant}, 3'b100, "reset")
        @(negedge clk);
        arst_n = 1'b1;
        rd_chk(OFS_PART_IDENTITY, {T_PART, T_MAKER});
        rd_chk(OFS_PART_REVISION_INFO, T_REV);
        rd_chk(OFS_BOARD_ASSEMBLY_IDENTITY, {T_ASSY, T_AMAKER});
        rd_chk(OFS_BOARD_ASSEMBLY_INFO, {T_AREV, T_PTR});
        spc_host_model_i.write_reg(OFS_PART_IDENTITY, 32'hffffffff, 4'hf);
        rd_chk(OFS_PART_IDENTITY, {T_PART, T_MAKER});
        spc_host_model_i.write_reg(OFS_BOARD_ASSEMBLY_INFO, 32'h00000000, 4'hf);
        rd_chk(OFS_BOARD_ASSEMBLY_INFO, {T_AREV, T_PTR});
        rd_chk(16'h0010, UNMAPPED_READ_VALUE);
        rd_chk(OFS_LINK_PORT_CONTROL, 32'h00200001);
        gate_sweep(1'b1);
        mc_pulse(1'b0);
        spc_host_model_i.write_reg(OFS_LINK_PORT_CONTROL, 32'hffffffff, 4'hf);
        rd_chk(OFS_LINK_PORT_CONTROL, 32'h00380001);
        `CHK({receive_accept_enable, error_recovery_off, mcast_participant}, 3'b111, "set")
        mc_pulse(1'b1);
        spc_host_model_i.write_reg(OFS_LINK_PORT_CONTROL, 32'h00000000, 4'b1011);
        rd_chk(OFS_LINK_PORT_CONTROL, 32'h00380001);
        spc_host_model_i.write_reg(OFS_LINK_PORT_CONTROL, 32'h00000000, 4'b0100);
        rd_chk(OFS_LINK_PORT_CONTROL, 32'h00000001);
        `CHK({receive_accept_enable, error_recovery_off, mcast_participant}, 3'b000, "clear")
        gate_sweep(1'b0);
        mc_pulse(1'b0);
        @(negedge clk);
        arst_n = 1'b0;
        #1;
        `CHK({receive_accept_enable, error_recovery_off, mcast_participant}, 3'b100, "re-reset")
        @(negedge clk);
        arst_n = 1'b1;
        rd_chk(OFS_LINK_PORT_CONTROL, 32'h00200001);
        close_out();
    end

    // Cuts a hang short well after the few dozen cycles the sequence needs.
    initial begin
        #20000;
        mismatches++;
        close_out();
    end
endmodule

`default_nettype wire
